// ### pbpu_pkg.sv
package pbpu_pkg;
  localparam int         DW             = 8;
  localparam int         AW             = 4;
  localparam logic [3:0] ADDR_PULLUP    = 4'h0;
  localparam logic [3:0] ADDR_ANALOG    = 4'h4;
  localparam logic [3:0] ADDR_DIRECTION = 4'h8;
  localparam logic [3:0] ADDR_CONTROL   = 4'hC;
  localparam logic [3:0] ADDR_LEVELS    = 4'h0;
  localparam logic [7:0] PULLUP_MASK    = 8'hF2;
  localparam logic [7:0] ANALOG_MASK    = 8'h72;
  localparam logic [7:0] DIR_MASK       = 8'hF3;
  localparam logic [7:0] PULLUP_RESET   = 8'hF2;
  localparam logic [7:0] ANALOG_RESET   = 8'h72;
  localparam logic [7:0] DIR_RESET      = 8'hF3;
  localparam int         CTRL_GPU_BIT   = 0;
  localparam logic       GPU_RESET      = 1'b1;

  typedef struct packed {
    logic [7:0] pullup_on;
    logic [7:0] dig_in_en;
    logic [7:0] ioc_allow;
  } pbpu_pin_ctl_t;
endpackage : pbpu_pkg

// ### pbpu_port_b_cfg.sv
// Overview of operation
// - each implemented pull-up enable bit (7..4, 1) requests a pull-up at 1.
// - bits 3, 2 and 0 of both registers ignore writes and read as zero.
// - pull-up on only with global enable, input dir, enable bit, not analog.
// - analog-select bits 6..4 and 1 at 1 mean analog, at 0 digital use.
// - analog mode forces off digital input, pull-up and change detection.
// - after reset the global pull-up control disables every pull-up.
// - a pin set as output never has its pull-up on.
// - digital reads of an analog pin return zero in that bit.
module pbpu_port_b_cfg (
  // clock and reset
  input  wire logic                  CLK_I,
  input  wire logic                  SYS_RST_I,
  // avalon-mm slave
  input  wire logic [3:0]            AVS_ADDRESS_I,
  input  wire logic                  AVS_READ_I,
  input  wire logic                  AVS_WRITE_I,
  input  wire logic [31:0]           AVS_WRITEDATA_I,
  input  wire logic [3:0]            AVS_BYTEENABLE_I,
  output logic [31:0]                AVS_READDATA_O,
  output logic                       AVS_WAITREQUEST_O,
  // pins
  input  wire logic [7:0]            PIN_LEVEL_I,
  output pbpu_pkg::pbpu_pin_ctl_t    PIN_CTL_O,
  output logic [7:0]                 PIN_DIR_INPUT_O
);
  // bus handshake: an access is answered one cycle after it is seen
  typedef enum logic [1:0] {
    PBPU_IDLE   = 2'b00,
    PBPU_ANSWER = 2'b01
  } pbpu_bus_state_t;

  pbpu_bus_state_t         state_reg;
  pbpu_bus_state_t         state_next;
  logic [7:0]              pullup_reg;
  logic [7:0]              analog_reg;
  logic [7:0]              dir_reg;
  logic                    gpu_disable_reg;
  logic [7:0]              lvl_meta_reg;
  logic [7:0]              lvl_sync_reg;
  logic                    wr_ok;
  logic                    rd_take;
  logic                    sel_pullup;
  logic                    sel_analog;
  logic                    sel_direction;
  logic                    sel_control;
  logic [31:0]             rd_next;
  logic [7:0]              pullup_on_next;
  logic [7:0]              dig_in_next;
  logic [7:0]              ioc_next;
  pbpu_pkg::pbpu_pin_ctl_t ctl_next;

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      PBPU_IDLE:
      begin
        if (AVS_READ_I || AVS_WRITE_I)
        begin
          state_next = PBPU_ANSWER;
        end
      end
      PBPU_ANSWER:
      begin
        // the master drops its request at this edge
        state_next = PBPU_IDLE;
      end
      default:
      begin
        state_next = PBPU_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK_I)
  begin
    if (SYS_RST_I)
    begin
      state_reg <= PBPU_IDLE;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // waitrequest is low exactly while the answer state lasts
  always_ff @(posedge CLK_I)
  begin
    if (SYS_RST_I)
    begin
      AVS_WAITREQUEST_O <= 1'b1;
    end
    else
    begin
      AVS_WAITREQUEST_O <= (state_next != PBPU_ANSWER);
    end
  end

  // a write lands only at the edge that sees waitrequest low
  assign wr_ok   = AVS_WRITE_I & (state_reg == PBPU_ANSWER)
                   & AVS_BYTEENABLE_I[0];
  // read data is loaded one edge early so it stands at the answer edge
  assign rd_take = AVS_READ_I & (state_reg == PBPU_IDLE);

  assign sel_pullup    = (AVS_ADDRESS_I == pbpu_pkg::ADDR_PULLUP);
  assign sel_analog    = (AVS_ADDRESS_I == pbpu_pkg::ADDR_ANALOG);
  assign sel_direction = (AVS_ADDRESS_I == pbpu_pkg::ADDR_DIRECTION);
  assign sel_control   = (AVS_ADDRESS_I == pbpu_pkg::ADDR_CONTROL);

  // pins arrive asynchronously
  always_ff @(posedge CLK_I)
  begin
    if (SYS_RST_I)
    begin
      lvl_meta_reg <= 8'h00;
      lvl_sync_reg <= 8'h00;
    end
    else
    begin
      lvl_meta_reg <= PIN_LEVEL_I;
      lvl_sync_reg <= lvl_meta_reg;
    end
  end

  always_ff @(posedge CLK_I)
  begin
    if (SYS_RST_I)
    begin
      pullup_reg <= pbpu_pkg::PULLUP_RESET;
    end
    else if (wr_ok && sel_pullup)
    begin
      pullup_reg <= AVS_WRITEDATA_I[7:0] & pbpu_pkg::PULLUP_MASK;
    end
  end

  always_ff @(posedge CLK_I)
  begin
    if (SYS_RST_I)
    begin
      analog_reg <= pbpu_pkg::ANALOG_RESET;
    end
    else if (wr_ok && sel_analog)
    begin
      analog_reg <= AVS_WRITEDATA_I[7:0] & pbpu_pkg::ANALOG_MASK;
    end
  end

  // direction stays free of analog select: analog pins may still drive
  always_ff @(posedge CLK_I)
  begin
    if (SYS_RST_I)
    begin
      dir_reg <= pbpu_pkg::DIR_RESET;
    end
    else if (wr_ok && sel_direction)
    begin
      dir_reg <= AVS_WRITEDATA_I[7:0] & pbpu_pkg::DIR_MASK;
    end
  end

  always_ff @(posedge CLK_I)
  begin
    if (SYS_RST_I)
    begin
      gpu_disable_reg <= pbpu_pkg::GPU_RESET;
    end
    else if (wr_ok && sel_control)
    begin
      gpu_disable_reg <= AVS_WRITEDATA_I[pbpu_pkg::CTRL_GPU_BIT];
    end
  end

  genvar bit_idx;
  generate
    for (bit_idx = 0; bit_idx < 8; bit_idx++)
    begin : g_pin
      // an analog pin loses its input path and change detection
      assign dig_in_next[bit_idx] = pbpu_pkg::DIR_MASK[bit_idx]
                                    & ~analog_reg[bit_idx];
      assign ioc_next[bit_idx]    = pbpu_pkg::DIR_MASK[bit_idx]
                                    & ~analog_reg[bit_idx];
      // output direction or global disable switches the pull-up off
      assign pullup_on_next[bit_idx] = ~gpu_disable_reg
                                       & dir_reg[bit_idx]
                                       & pullup_reg[bit_idx]
                                       & ~analog_reg[bit_idx];
    end
  endgenerate

  // pin levels sit in the control word, masked by the input path
  always_comb
  begin
    rd_next = 32'h0000_0000;
    case (AVS_ADDRESS_I)
      pbpu_pkg::ADDR_PULLUP:
      begin
        rd_next[7:0] = pullup_reg;
      end
      pbpu_pkg::ADDR_ANALOG:
      begin
        rd_next[7:0] = analog_reg;
      end
      pbpu_pkg::ADDR_DIRECTION:
      begin
        rd_next[7:0] = dir_reg;
      end
      pbpu_pkg::ADDR_CONTROL:
      begin
        rd_next[pbpu_pkg::CTRL_GPU_BIT] = gpu_disable_reg;
        rd_next[15:8] = lvl_sync_reg & dig_in_next;
      end
      default:
      begin
        rd_next = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge CLK_I)
  begin
    if (SYS_RST_I)
    begin
      AVS_READDATA_O <= 32'h0000_0000;
    end
    else if (rd_take)
    begin
      AVS_READDATA_O <= rd_next;
    end
  end

  always_comb
  begin
    ctl_next.pullup_on = pullup_on_next;
    ctl_next.dig_in_en = dig_in_next;
    ctl_next.ioc_allow = ioc_next;
  end

  // controls and direction copy leave on the same edge
  always_ff @(posedge CLK_I)
  begin
    if (SYS_RST_I)
    begin
      PIN_CTL_O       <= '0;
      PIN_DIR_INPUT_O <= pbpu_pkg::DIR_RESET;
    end
    else
    begin
      PIN_CTL_O       <= ctl_next;
      PIN_DIR_INPUT_O <= dir_reg;
    end
  end
endmodule : pbpu_port_b_cfg

// ### pbpu_sva.sv
module pbpu_sva (
  input wire logic                    CLK_I,
  input wire logic                    SYS_RST_I,
  input wire logic                    AVS_READ_I,
  input wire logic                    AVS_WRITE_I,
  input wire logic [31:0]             AVS_READDATA_O,
  input wire logic                    AVS_WAITREQUEST_O,
  input wire pbpu_pkg::pbpu_pin_ctl_t PIN_CTL_O,
  input wire logic [7:0]              PIN_DIR_INPUT_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (SYS_RST_I);
  AST_ACK: assert property ($rose(AVS_READ_I | AVS_WRITE_I) |=>
    !AVS_WAITREQUEST_O) else $error("late answer");
  AST_ONE: assert property (!AVS_WAITREQUEST_O |=> AVS_WAITREQUEST_O)
    else $error("long answer");
  AST_IDLE: assert property (!(AVS_READ_I | AVS_WRITE_I) |=>
    AVS_WAITREQUEST_O) else $error("answer without request");
  AST_RST: assert property (disable iff (1'b0) SYS_RST_I |=>
    AVS_READDATA_O == 32'h0 && PIN_CTL_O == '0) else $error("reset state");
  AST_PU_AN: assert property ((PIN_CTL_O.pullup_on &
    ~PIN_CTL_O.dig_in_en) == 8'h00) else $error("pullup on analog pin");
  AST_PU_MSK: assert property ((PIN_CTL_O.pullup_on & ~8'hF2) == 8'h00)
    else $error("pullup on missing bit");
  AST_IOC: assert property (PIN_CTL_O.ioc_allow == PIN_CTL_O.dig_in_en)
    else $error("change detect on analog pin");
  AST_PU_DIR: assert property ((PIN_CTL_O.pullup_on &
    ~PIN_DIR_INPUT_O) == 8'h00) else $error("pullup on output");
endmodule : pbpu_sva
bind pbpu_port_b_cfg pbpu_sva u_sva (.CLK_I, .SYS_RST_I, .AVS_READ_I,
  .AVS_WRITE_I, .AVS_READDATA_O, .AVS_WAITREQUEST_O, .PIN_CTL_O,
  .PIN_DIR_INPUT_O);

// ### testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 0, rst = 1, rd_r = 0, wr_r = 0, wq, g;
  logic [3:0]  adr = 4'h0, be = 4'hF;
  logic [31:0] wd = 32'h0, rdat, s = 32'h700589DA, q[$];
  logic [7:0]  lvl, dir, p, a, d;
  pbpu_pkg::pbpu_pin_ctl_t ctl;
  int          num_errors = 0, num_checks = 0;
  always #20 clk = ~clk;
  pbpu_port_b_cfg u_pbpu_port_b_cfg (.CLK_I(clk), .SYS_RST_I(rst),
    .AVS_ADDRESS_I(adr), .AVS_READ_I(rd_r), .AVS_WRITE_I(wr_r),
    .AVS_WRITEDATA_I(wd), .AVS_BYTEENABLE_I(be), .AVS_READDATA_O(rdat),
    .AVS_WAITREQUEST_O(wq), .PIN_LEVEL_I(lvl), .PIN_CTL_O(ctl),
    .PIN_DIR_INPUT_O(dir));
  function automatic logic [31:0] rnd();
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : rnd
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task finish_test();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : finish_test
  // request held until the edge that samples waitrequest low
  task bus(input logic w, input logic [3:0] ad, input logic [7:0] dt);
    rd_r <= !w;
    wr_r <= w;
    adr <= ad;
    wd <= {24'h0, dt};
    do @(posedge clk); while (wq !== 1'b0);
    rd_r <= 1'b0;
    wr_r <= 1'b0;
    @(posedge clk);
  endtask : bus
  task rd(input logic [3:0] ad, input logic [31:0] exp);
    q.push_back(exp);
    bus(1'b0, ad, 8'h00);
  endtask : rd
  always @(posedge clk)
    if (rd_r && wq === 1'b0) chk(rdat, q.pop_front());
  initial
  begin
    lvl <= 8'(rnd());
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk({8'h0, ctl}, 32'h0);
    @(posedge clk);
    rd(4'h0, 32'hF2);
    rd(4'h4, 32'h72);
    rd(4'hC, {16'h0, lvl & 8'h81, 8'h01});
    rd(4'h2, 32'h0);
    repeat (24)
    begin
      lvl <= 8'(rnd());
      {p, a, d, g} = 25'(rnd());
      d = d | (a & 8'h72);
      bus(1'b1, 4'h0, p);
      bus(1'b1, 4'h4, a);
      bus(1'b1, 4'h8, d);
      bus(1'b1, 4'hC, {7'h0, g});
      rd(4'h0, p & 8'hF2);
      rd(4'h4, a & 8'h72);
      rd(4'hC, {16'h0, lvl & 8'hF3 & ~(a & 8'h72), 7'h0, g});
      @(negedge clk);
      chk({ctl.pullup_on, ctl.dig_in_en, ctl.ioc_allow, dir},
        {~{8{g}} & d & p & 8'hF2 & ~(a & 8'h72), 8'hF3 & ~(a & 8'h72),
         8'hF3 & ~(a & 8'h72), d & 8'hF3});
      @(posedge clk);
    end
    // a write without the low byte lane leaves the register alone
    be <= 4'hE;
    bus(1'b1, 4'h0, ~p);
    be <= 4'hF;
    rd(4'h0, p & 8'hF2);
    finish_test();
  end
  initial
  begin
    #100000;
    num_errors++;
    finish_test();
  end
endmodule : testbench
